// file: debug_uart_rx.sv
`timescale 1ns/1ps
`default_nettype none
// Notes on behaviour
// [R01] Asynchronous only, 8-bit characters, optional parity, no clock pin.
// [R02] Receiver and transmitter independent, sharing one baud tick.
// [R03] No receive idle timeout and no transmit guard time.
// [R04] Bit rate is clock over sixteen times divisor.
// [R05] Divisor zero stops the baud clock; port stays inactive.
// [R06] Divisor values up to 65536 are supported.
// [R07] Receiver off after reset; enable command starts start-bit search.
// [R08] Disable stops at once when idle, else after the stop bit.
// [R09] Receiver reset aborts any character and leaves receiver disabled.
// [R10] Start bit needs low for more than 7 sampling ticks.
// [R11] First data sample 24 ticks after the detected falling edge.
// [R12] Each later bit sampled 16 ticks after the previous one.
// [R13] Full character goes to holding register and sets ready flag.
// [R14] Reading holding register, by software or channel, clears ready.
// [R15] Debug channel read/write status visible and can raise interrupt.
// [R16] Software bit forces tap reset to block emulator access.
// [R17] Character completing while ready is set sets sticky overrun.
// [R18] Parity mismatch sets sticky parity error with ready.
// [R19] Low stop bit sets sticky framing error with ready.
// [R20] Parity modes: none, odd, even, forced space, forced mark.
// [R21] Far end sends start, 8 data LSB first, parity, stop.
// [R22] Receive line idles high and is resynchronised before detection.
module debug_uart_rx #(
  parameter int DIV_W = debug_uart_pkg::DIV_W
) (
  // Clock, reset, enable.
  input wire logic clk_in,
  input wire logic nrst_in,
  input wire logic ce_in,
  // APB slave.
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [7:0] paddr_in,
  input wire logic [31:0] pwdata_in,
  output logic [31:0] prdata_out,
  output logic pready_out,
  output logic pslverr_out,
  // Serial and debug-channel inputs.
  input wire logic serial_rx_pin_in,
  input wire logic dcc_rx_full_in,
  input wire logic dcc_tx_full_in,
  // Transfer channel and neighbours.
  input wire logic rhr_channel_read_in,
  output logic rx_ready_out,
  output logic baud_tick_out,
  output logic dcc_irq_out,
  output logic tap_reset_out
);

  typedef struct packed {
    debug_uart_pkg::rx_state_t st;
    logic [4:0] cnt;
    logic [2:0] bit_idx;
    logic [7:0] shift;
    logic par_acc;
    logic par_bad;
    logic enabled;
    logic stop_pending;
    logic [7:0] hold;
    debug_uart_pkg::rx_flags_t flags;
    logic [2:0] par_mode;
    logic [1:0] dcc_irq_en;
    logic [DIV_W-1:0] divisor;
    logic tap_force;
    logic irq;
    logic [31:0] rdata;
  } rx_reg_t;

  localparam rx_reg_t RESET_STATE = '{
    st: debug_uart_pkg::RX_IDLE,
    par_mode: debug_uart_pkg::MODE_PAR_RESET,
    divisor: DIV_W'(debug_uart_pkg::BAUD_RESET),
    default: '0
  };

  rx_reg_t cur;
  rx_reg_t next_cur;
  logic tick;
  logic rx;
  logic [1:0] dcc;
  logic [2:0] synced;

  ////////////////////////////////////////////////////////////////////////////
  // Line resynchronisation and sampling clock.

  debug_uart_sync #(.W(3), .RESET_VAL(3'h1)) u_sync (
    .clk_in(clk_in),
    .nrst_in(nrst_in),
    .ce_in(ce_in),
    .d_in({dcc_tx_full_in, dcc_rx_full_in, serial_rx_pin_in}),
    .q_out(synced)
  ); // R22

  assign rx = synced[0];
  assign dcc = synced[2:1];

  debug_uart_baud #(.DIV_W(DIV_W)) u_baud (
    .clk_in(clk_in),
    .nrst_in(nrst_in),
    .ce_in(ce_in),
    .divisor_in(cur.divisor),
    .tick_out(tick)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Bus decode.

  logic setup;
  logic wr;
  logic rd_rhr;
  logic ctrl_wr;
  logic mapped;
  logic sample;
  logic done;

  assign setup = psel_in && !penable_in;
  assign wr = psel_in && penable_in && pwrite_in;
  assign ctrl_wr = wr && paddr_in == debug_uart_pkg::OFF_CTRL;
  assign rd_rhr = (psel_in && penable_in && !pwrite_in && paddr_in == debug_uart_pkg::OFF_RHR)
    || rhr_channel_read_in;
  assign mapped = paddr_in inside {debug_uart_pkg::OFF_CTRL, debug_uart_pkg::OFF_MODE,
    debug_uart_pkg::OFF_STATUS, debug_uart_pkg::OFF_RHR, debug_uart_pkg::OFF_BAUD,
    debug_uart_pkg::OFF_TAP};
  assign sample = tick && cur.cnt == debug_uart_pkg::OVERSAMPLE - 5'h01;
  assign done = cur.st == debug_uart_pkg::RX_STOP && sample;

  ////////////////////////////////////////////////////////////////////////////
  // Next state.

  always_comb begin
    logic [31:0] word;
    word = '0;
    next_cur = cur;
    // Clears come first so that a same-cycle set wins.
    if (rd_rhr) begin
      next_cur.flags.ready = 1'b0; // R14
    end
    if (ctrl_wr && pwdata_in[debug_uart_pkg::CTRL_CLEAR_FLAGS]) begin
      next_cur.flags.overrun = 1'b0;
      next_cur.flags.frame_err = 1'b0;
      next_cur.flags.parity_err = 1'b0;
    end
    // Without ticks (divisor zero) the receiver never moves.
    case (cur.st)
      debug_uart_pkg::RX_IDLE: begin // R03
        if (cur.enabled && tick && !rx) begin
          next_cur.st = debug_uart_pkg::RX_START;
          next_cur.cnt = '0;
        end
      end
      debug_uart_pkg::RX_START: begin
        if (tick) begin
          next_cur.cnt = cur.cnt + 5'h01;
          if (rx && cur.cnt < debug_uart_pkg::START_MIN) begin
            next_cur.st = debug_uart_pkg::RX_IDLE; // R10
          end else if (cur.cnt == debug_uart_pkg::FIRST_SAMPLE - 5'h01) begin
            next_cur.st = debug_uart_pkg::RX_DATA; // R11
            next_cur.cnt = '0;
            next_cur.shift = {rx, cur.shift[7:1]};
            next_cur.par_acc = rx;
            next_cur.bit_idx = 3'h1;
          end
        end
      end
      debug_uart_pkg::RX_DATA: begin
        if (tick) begin
          next_cur.cnt = cur.cnt + 5'h01;
        end
        if (sample) begin
          next_cur.cnt = '0; // R12
          next_cur.shift = {rx, cur.shift[7:1]}; // R21
          next_cur.par_acc = cur.par_acc ^ rx;
          next_cur.bit_idx = cur.bit_idx + 3'h1;
          if (cur.bit_idx == debug_uart_pkg::LAST_BIT) begin
            // Codes four and up all mean no parity bit.
            next_cur.st = cur.par_mode[2] ? debug_uart_pkg::RX_STOP
              : debug_uart_pkg::RX_PARITY; // R01
            next_cur.par_bad = 1'b0;
          end
        end
      end
      debug_uart_pkg::RX_PARITY: begin
        if (tick) begin
          next_cur.cnt = cur.cnt + 5'h01;
        end
        if (sample) begin
          next_cur.cnt = '0;
          next_cur.st = debug_uart_pkg::RX_STOP;
          case (cur.par_mode)
            debug_uart_pkg::PAR_EVEN: next_cur.par_bad = rx != cur.par_acc; // R20
            debug_uart_pkg::PAR_ODD: next_cur.par_bad = rx == cur.par_acc;
            debug_uart_pkg::PAR_SPACE: next_cur.par_bad = rx;
            debug_uart_pkg::PAR_MARK: next_cur.par_bad = !rx;
            default: next_cur.par_bad = 1'b0;
          endcase
        end
      end
      debug_uart_pkg::RX_STOP: begin
        if (tick) begin
          next_cur.cnt = cur.cnt + 5'h01;
        end
        if (done) begin
          next_cur.cnt = '0;
          next_cur.st = debug_uart_pkg::RX_IDLE;
          next_cur.hold = cur.shift; // R13
          next_cur.flags.ready = 1'b1;
          if (cur.flags.ready && !rd_rhr) begin
            next_cur.flags.overrun = 1'b1; // R17
          end
          if (cur.par_bad) begin
            next_cur.flags.parity_err = 1'b1; // R18
          end
          if (!rx) begin
            next_cur.flags.frame_err = 1'b1; // R19
          end
          if (cur.stop_pending) begin
            next_cur.enabled = 1'b0; // R08
            next_cur.stop_pending = 1'b0;
          end
        end
      end
      default: begin
        next_cur.st = debug_uart_pkg::RX_IDLE;
      end
    endcase
    // Commands: reset, then enable, then disable, so disable wins.
    if (ctrl_wr) begin
      if (pwdata_in[debug_uart_pkg::CTRL_RX_RESET]) begin
        next_cur.st = debug_uart_pkg::RX_IDLE; // R09
        next_cur.cnt = '0;
        next_cur.enabled = 1'b0;
        next_cur.stop_pending = 1'b0;
      end
      if (pwdata_in[debug_uart_pkg::CTRL_RX_ENABLE]) begin
        next_cur.enabled = 1'b1; // R07
        next_cur.stop_pending = 1'b0;
      end
      if (pwdata_in[debug_uart_pkg::CTRL_RX_DISABLE]) begin
        if (next_cur.st == debug_uart_pkg::RX_IDLE) begin
          next_cur.enabled = 1'b0; // R08
        end else begin
          next_cur.stop_pending = 1'b1;
        end
      end
    end
    if (wr && paddr_in == debug_uart_pkg::OFF_MODE) begin
      next_cur.par_mode = pwdata_in[debug_uart_pkg::MODE_PAR_LSB +: 3];
      next_cur.dcc_irq_en = pwdata_in[debug_uart_pkg::MODE_DCC_LSB +: 2];
    end
    if (wr && paddr_in == debug_uart_pkg::OFF_BAUD) begin
      next_cur.divisor = pwdata_in[DIV_W-1:0]; // R06
    end
    if (wr && paddr_in == debug_uart_pkg::OFF_TAP) begin
      next_cur.tap_force = pwdata_in[0]; // R16
    end
    next_cur.irq = |(dcc & cur.dcc_irq_en); // R15
    // Read data is latched in the setup cycle from the updated state,
    // so a character landing at that edge is never read stale.
    if (setup) begin
      case (paddr_in)
        debug_uart_pkg::OFF_MODE: begin
          word[debug_uart_pkg::MODE_PAR_LSB +: 3] = next_cur.par_mode;
          word[debug_uart_pkg::MODE_DCC_LSB +: 2] = next_cur.dcc_irq_en;
        end
        debug_uart_pkg::OFF_STATUS: begin
          word[debug_uart_pkg::ST_RX_READY] = next_cur.flags.ready;
          word[debug_uart_pkg::ST_RX_ON] = next_cur.enabled;
          word[debug_uart_pkg::ST_OVERRUN] = next_cur.flags.overrun;
          word[debug_uart_pkg::ST_FRAME] = next_cur.flags.frame_err;
          word[debug_uart_pkg::ST_PARITY] = next_cur.flags.parity_err;
          word[debug_uart_pkg::ST_DCC_RX] = dcc[0]; // R15
          word[debug_uart_pkg::ST_DCC_TX] = dcc[1];
        end
        debug_uart_pkg::OFF_RHR: word[7:0] = next_cur.hold;
        debug_uart_pkg::OFF_BAUD: word[DIV_W-1:0] = next_cur.divisor;
        debug_uart_pkg::OFF_TAP: word[0] = next_cur.tap_force;
        default: word = '0;
      endcase
      next_cur.rdata = word;
    end
  end

  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      cur <= RESET_STATE;
    end else if (ce_in) begin
      cur <= next_cur;
    end
  end

  // A frozen block must not complete bus transfers it cannot act on.
  assign pready_out = ce_in;
  assign pslverr_out = psel_in && penable_in && !mapped;
  assign prdata_out = cur.rdata;
  assign rx_ready_out = cur.flags.ready;
  assign baud_tick_out = tick; // R02
  assign dcc_irq_out = cur.irq;
  assign tap_reset_out = cur.tap_force;

  ////////////////////////////////////////////////////////////////////////////
  // Checks.

  default clocking @(posedge clk_in); endclocking
  default disable iff (!nrst_in);

  a_reset_aborts: assert property (ce_in && ctrl_wr && pwdata_in[debug_uart_pkg::CTRL_RX_RESET]
    && !pwdata_in[debug_uart_pkg::CTRL_RX_ENABLE]
    |=> cur.st == debug_uart_pkg::RX_IDLE && !cur.enabled) // R09
    else $error("Receiver reset did not abort.");
  a_start_reject: assert property (ce_in && !ctrl_wr && cur.st == debug_uart_pkg::RX_START
    && tick && rx && cur.cnt < debug_uart_pkg::START_MIN
    |=> cur.st == debug_uart_pkg::RX_IDLE) // R10
    else $error("Short low not rejected.");
  a_first_sample: assert property (ce_in && !ctrl_wr && cur.st == debug_uart_pkg::RX_START
    && tick && cur.cnt == 5'h17 |=> cur.st == debug_uart_pkg::RX_DATA
    && cur.shift[7] == $past(rx)) // R11
    else $error("First data sample misplaced.");
  a_bit_spacing: assert property (ce_in && !ctrl_wr && cur.st == debug_uart_pkg::RX_DATA
    && tick && cur.cnt != 5'h0F |=> cur.st == debug_uart_pkg::RX_DATA
    && cur.bit_idx == $past(cur.bit_idx)) // R12
    else $error("Data bit sampled early.");
  a_char_lands: assert property (ce_in && done |=> cur.flags.ready
    && cur.hold == $past(cur.shift)) // R13
    else $error("Character not moved to holding register.");
  a_read_clears: assert property (ce_in && rd_rhr && !done |=> !cur.flags.ready) // R14
    else $error("Ready not cleared by read.");
  a_overrun_set: assert property (ce_in && done && cur.flags.ready && !rd_rhr
    |=> cur.flags.overrun) // R17
    else $error("Overrun missed.");
  a_frame_set: assert property (ce_in && done && !rx |=> cur.flags.frame_err) // R19
    else $error("Framing error missed.");
  a_parity_set: assert property (ce_in && done && cur.par_bad |=> cur.flags.parity_err) // R18
    else $error("Parity error missed.");
  a_disable_idle: assert property (ce_in && ctrl_wr && cur.st == debug_uart_pkg::RX_IDLE
    && pwdata_in[debug_uart_pkg::CTRL_RX_DISABLE] && !(cur.enabled && tick && !rx)
    |=> !cur.enabled) // R08
    else $error("Idle receiver not disabled.");
  a_tap_force: assert property (ce_in && wr && paddr_in == debug_uart_pkg::OFF_TAP
    |=> tap_reset_out == $past(pwdata_in[0])) // R16
    else $error("Tap reset not following write.");

  c_char: cover property (ce_in && done && rx);
  c_overrun: cover property (ce_in && done && cur.flags.ready);
  c_parity: cover property (ce_in && done && cur.par_bad);
  c_glitch: cover property (cur.st == debug_uart_pkg::RX_START
    ##1 cur.st == debug_uart_pkg::RX_IDLE);

endmodule : debug_uart_rx
`default_nettype wire

// file: debug_uart_pkg.sv
`default_nettype none
package debug_uart_pkg;

  // Register byte offsets.
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_MODE = 8'h04;
  localparam logic [7:0] OFF_STATUS = 8'h14;
  localparam logic [7:0] OFF_RHR = 8'h18;
  localparam logic [7:0] OFF_BAUD = 8'h20;
  localparam logic [7:0] OFF_TAP = 8'h40;

  // Control command bits.
  localparam int CTRL_RX_RESET = 2;
  localparam int CTRL_RX_ENABLE = 4;
  localparam int CTRL_RX_DISABLE = 5;
  localparam int CTRL_CLEAR_FLAGS = 8;

  // Mode fields.
  localparam int MODE_PAR_LSB = 9;
  localparam int MODE_DCC_LSB = 30;
  localparam logic [2:0] MODE_PAR_RESET = 3'h4;

  // Status bits.
  localparam int ST_RX_READY = 0;
  localparam int ST_RX_ON = 4;
  localparam int ST_OVERRUN = 5;
  localparam int ST_FRAME = 6;
  localparam int ST_PARITY = 7;
  localparam int ST_DCC_RX = 30;
  localparam int ST_DCC_TX = 31;

  // Divisor width covers 65536; zero stops the generator.
  localparam int DIV_W = 17;
  localparam logic [16:0] BAUD_RESET = 17'h00000;

  // Timing in sampling-clock ticks.
  localparam logic [4:0] START_MIN = 5'h07;
  localparam logic [4:0] FIRST_SAMPLE = 5'h18;
  localparam logic [4:0] OVERSAMPLE = 5'h10;
  localparam logic [2:0] LAST_BIT = 3'h7;

  typedef enum logic [2:0] {
    PAR_EVEN = 3'h0,
    PAR_ODD = 3'h1,
    PAR_SPACE = 3'h2,
    PAR_MARK = 3'h3,
    PAR_NONE = 3'h4
  } parity_mode_t;

  typedef enum logic [4:0] {
    RX_IDLE = 5'h01,
    RX_START = 5'h02,
    RX_DATA = 5'h04,
    RX_PARITY = 5'h08,
    RX_STOP = 5'h10
  } rx_state_t;

  typedef struct packed {
    logic ready;
    logic overrun;
    logic frame_err;
    logic parity_err;
  } rx_flags_t;

endpackage : debug_uart_pkg
`default_nettype wire

// file: debug_uart_sync.sv
`timescale 1ns/1ps
`default_nettype none
module debug_uart_sync #(
  parameter int W = 1,
  parameter logic [W-1:0] RESET_VAL = '0
) (
  // Clock, reset, enable.
  input wire logic clk_in,
  input wire logic nrst_in,
  input wire logic ce_in,
  // Asynchronous inputs and filtered result.
  input wire logic [W-1:0] d_in,
  output logic [W-1:0] q_out
);

  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] s3;
    logic [W-1:0] q;
  } sync_state_t;

  localparam sync_state_t RESET_STATE = '{RESET_VAL, RESET_VAL, RESET_VAL, RESET_VAL};

  sync_state_t cur;
  sync_state_t next_cur;

  // A change is accepted only when the second and third stages agree.
  always_comb begin
    next_cur.s1 = d_in;
    next_cur.s2 = cur.s1;
    next_cur.s3 = cur.s2;
    next_cur.q = (cur.s2 & cur.s3) | (cur.q & (cur.s2 ^ cur.s3));
  end

  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      cur <= RESET_STATE;
    end else if (ce_in) begin
      cur <= next_cur;
    end
  end

  assign q_out = cur.q;

endmodule : debug_uart_sync
`default_nettype wire

// file: debug_uart_baud.sv
`timescale 1ns/1ps
`default_nettype none
module debug_uart_baud #(
  parameter int DIV_W = debug_uart_pkg::DIV_W
) (
  // Clock, reset, enable.
  input wire logic clk_in,
  input wire logic nrst_in,
  input wire logic ce_in,
  // Divisor and sampling tick.
  input wire logic [DIV_W-1:0] divisor_in,
  output logic tick_out
);

  typedef struct packed {
    logic [DIV_W-1:0] cnt;
    logic tick;
  } baud_state_t;

  baud_state_t cur;
  baud_state_t next_cur;

  // One tick every divisor clocks gives the 16x sampling rate.
  always_comb begin
    next_cur.cnt = '0;
    next_cur.tick = 1'b0;
    if (divisor_in != '0) begin // R05
      if (cur.cnt >= divisor_in - 1'b1) begin
        next_cur.tick = 1'b1; // R04
      end else begin
        next_cur.cnt = cur.cnt + 1'b1; // R06
      end
    end
  end

  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      cur <= '0;
    end else if (ce_in) begin
      cur <= next_cur;
    end
  end

  assign tick_out = cur.tick;

  default clocking @(posedge clk_in); endclocking
  default disable iff (!nrst_in);

  a_div_zero_stops: assert property (ce_in && divisor_in == '0 |=> !tick_out) // R05
    else $error("Tick seen with zero divisor.");
  a_tick_spacing: assert property (ce_in && tick_out && divisor_in == 17'h00002
    ##1 ce_in && divisor_in == 17'h00002 |=> tick_out) // R04
    else $error("Tick spacing wrong for divisor two.");

endmodule : debug_uart_baud
`default_nettype wire

// file: serial_terminal_model.sv
`timescale 1ns/1ps
`default_nettype none
module serial_terminal_model #(
  parameter int BIT_CLKS = 16
) (
  // Clock and serial line.
  input wire logic clk_in,
  output logic line_out
);
  // The line rests at the idle level, so a frame only starts on command.
  initial line_out = 1'b1;

  task automatic hold(input logic v, input int n);
    line_out <= v;
    repeat (n) @(posedge clk_in);
  endtask : hold

  // A par value of 0 or 1 sends that check bit; any other value sends none.
  task automatic send(input logic [7:0] data, input int par, input logic stop);
    @(posedge clk_in);
    hold(1'b0, BIT_CLKS);
    for (int i = 0; i < 8; i++) hold(data[i], BIT_CLKS);
    if (par == 0 || par == 1) hold(par[0], BIT_CLKS);
    hold(stop, BIT_CLKS);
    line_out <= 1'b1;
  endtask : send

  task automatic glitch(input int n);
    @(posedge clk_in);
    hold(1'b0, n);
    line_out <= 1'b1;
  endtask : glitch
endmodule : serial_terminal_model
`default_nettype wire

// file: debug_uart_receiver_baud_tb.sv
`timescale 1ns/1ps
`default_nettype none
module debug_uart_receiver_baud_tb;
  logic clk_in, nrst_in, psel, penable, pwrite, pready, pslverr, line;
  logic dcc_rx, dcc_tx, ch_read, rx_ready, tick, irq, tap, err;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, r;
  int n_errors = 0;
  int compares = 0;
  int cyc = 0;
  localparam logic [7:0] ST = debug_uart_pkg::OFF_STATUS;
  localparam logic [7:0] RHR = debug_uart_pkg::OFF_RHR;
  localparam logic [31:0] EN = 32'h1 << debug_uart_pkg::CTRL_RX_ENABLE;
  localparam logic [31:0] DIS = 32'h1 << debug_uart_pkg::CTRL_RX_DISABLE;
  localparam logic [31:0] RST = 32'h1 << debug_uart_pkg::CTRL_RX_RESET;
  localparam logic [31:0] CLR = 32'h1 << debug_uart_pkg::CTRL_CLEAR_FLAGS;

  debug_uart_rx i_debug_uart_rx (.clk_in(clk_in), .nrst_in(nrst_in), .ce_in(1'b1),
    .psel_in(psel), .penable_in(penable), .pwrite_in(pwrite), .paddr_in(paddr),
    .pwdata_in(pwdata), .prdata_out(prdata), .pready_out(pready), .pslverr_out(pslverr),
    .serial_rx_pin_in(line), .dcc_rx_full_in(dcc_rx), .dcc_tx_full_in(dcc_tx),
    .rhr_channel_read_in(ch_read), .rx_ready_out(rx_ready), .baud_tick_out(tick),
    .dcc_irq_out(irq), .tap_reset_out(tap));
  serial_terminal_model i_serial_terminal_model (.clk_in(clk_in), .line_out(line));

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    clk_in = 1'b0;
    forever #4 clk_in = ~clk_in;
  end

  // A hang anywhere ends the run through the same closing report.
  always @(posedge clk_in) begin
    cyc++;
    if (cyc == 50000) begin
      n_errors++;
      test_done();
    end
  end

  task automatic test_done();
    $display("checks %0d mismatches %0d", compares, n_errors);
    if (n_errors == 0 && compares > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : test_done

  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      n_errors++;
      $display("FAIL %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk

  ////////////////////////////////////////////////////////////////////////////////
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_in);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_in);
    penable <= 1'b1;
    do @(posedge clk_in); while (pready !== 1'b1);
    r = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask : wr

  task automatic rdc(input string what, input logic [7:0] a, input logic [31:0] m,
                     input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(what, r & m, exp);
  endtask : rdc

  task automatic clocks(input int n);
    repeat (n) @(posedge clk_in);
    #1;
  endtask : clocks

  ////////////////////////////////////////////////////////////////////////////////
  task automatic t_reset();
    rdc("status", ST, 32'hFFFFFFFF, 32'h0);
    wr(debug_uart_pkg::OFF_CTRL, EN);
    i_serial_terminal_model.send(8'h42, 2, 1'b1);
    clocks(4);
    chk("tick", {31'h0, tick}, 32'h0);
    rdc("ready", ST, 32'h1, 32'h0);
    apb(1'b0, 8'h08, 32'h0);
    chk("slverr", {31'h0, err}, 32'h1);
    $display("test reset done");
  endtask : t_reset

  task automatic t_baud();
    int n;
    n = 0;
    wr(debug_uart_pkg::OFF_BAUD, 32'h2);
    do clocks(1); while (tick !== 1'b1);
    do begin
      clocks(1);
      n++;
    end while (tick !== 1'b1 && n < 20);
    chk("tick gap", 32'(n), 32'h2);
    wr(debug_uart_pkg::OFF_BAUD, 32'h1);
    $display("test baud done");
  endtask : t_baud

  task automatic t_parity();
    logic [7:0] d;
    int p;
    for (int m = 0; m < 5; m++) begin
      d = 8'h96 + 8'(m);
      p = (m == 0) ? int'(^d) : (m == 1) ? int'(~^d) : (m == 2) ? 0 : (m == 3) ? 1 : 2;
      wr(debug_uart_pkg::OFF_MODE, 32'(m) << debug_uart_pkg::MODE_PAR_LSB);
      i_serial_terminal_model.send(d, p, 1'b1);
      clocks(2);
      rdc("status", ST, 32'hE1, 32'h1);
      rdc("data", RHR, 32'hFF, {24'h0, d});
      rdc("ready", ST, 32'h1, 32'h0);
    end
    wr(debug_uart_pkg::OFF_MODE, 32'h0);
    i_serial_terminal_model.send(8'h07, 0, 1'b1);
    clocks(2);
    rdc("parity", ST, 32'hE1, 32'h81);
    rdc("data", RHR, 32'hFF, 32'h7);
    rdc("parity", ST, 32'hE1, 32'h80);
    wr(debug_uart_pkg::OFF_CTRL, CLR);
    rdc("cleared", ST, 32'hE1, 32'h0);
    $display("test parity done");
  endtask : t_parity

  task automatic t_frame_over();
    wr(debug_uart_pkg::OFF_MODE, 32'h4 << debug_uart_pkg::MODE_PAR_LSB);
    i_serial_terminal_model.send(8'h3C, 2, 1'b0);
    clocks(2);
    rdc("frame", ST, 32'hE1, 32'h41);
    wr(debug_uart_pkg::OFF_CTRL, CLR);
    rdc("data", RHR, 32'hFF, 32'h3C);
    i_serial_terminal_model.send(8'h11, 2, 1'b1);
    i_serial_terminal_model.send(8'h22, 2, 1'b1);
    clocks(2);
    rdc("overrun", ST, 32'hE1, 32'h21);
    ch_read <= 1'b1;
    @(posedge clk_in);
    ch_read <= 1'b0;
    clocks(1);
    chk("ready pin", {31'h0, rx_ready}, 32'h0);
    rdc("overrun", ST, 32'hE1, 32'h20);
    wr(debug_uart_pkg::OFF_CTRL, CLR);
    rdc("cleared", ST, 32'hE1, 32'h0);
    $display("test frame and overrun done");
  endtask : t_frame_over

  task automatic t_start_detect();
    i_serial_terminal_model.glitch(7);
    clocks(400);
    chk("glitch", {31'h0, rx_ready}, 32'h0);
    i_serial_terminal_model.send(8'h5A, 2, 1'b1);
    clocks(2);
    rdc("data", RHR, 32'hFF, 32'h5A);
    $display("test start detect done");
  endtask : t_start_detect

  task automatic t_disable_reset();
    fork
      i_serial_terminal_model.send(8'hC3, 2, 1'b1);
      begin
        clocks(40);
        wr(debug_uart_pkg::OFF_CTRL, DIS);
      end
    join
    clocks(2);
    rdc("late off", ST, 32'h11, 32'h1);
    rdc("data", RHR, 32'hFF, 32'hC3);
    i_serial_terminal_model.send(8'h99, 2, 1'b1);
    clocks(2);
    rdc("off", ST, 32'h11, 32'h0);
    wr(debug_uart_pkg::OFF_CTRL, EN);
    fork
      i_serial_terminal_model.send(8'h77, 2, 1'b1);
      begin
        clocks(60);
        wr(debug_uart_pkg::OFF_CTRL, RST);
      end
    join
    clocks(2);
    rdc("aborted", ST, 32'h11, 32'h0);
    wr(debug_uart_pkg::OFF_CTRL, EN);
    i_serial_terminal_model.send(8'h81, 2, 1'b1);
    clocks(2);
    rdc("data", RHR, 32'hFF, 32'h81);
    wr(debug_uart_pkg::OFF_CTRL, DIS);
    rdc("idle off", ST, 32'h10, 32'h0);
    $display("test disable and reset done");
  endtask : t_disable_reset

  task automatic t_debug();
    dcc_rx <= 1'b1;
    wr(debug_uart_pkg::OFF_MODE, 32'h1 << debug_uart_pkg::MODE_DCC_LSB);
    rdc("dcc", ST, 32'hC0000000, 32'h40000000);
    clocks(8);
    chk("dcc irq", {31'h0, irq}, 32'h1);
    @(posedge clk_in);
    dcc_rx <= 1'b0;
    dcc_tx <= 1'b1;
    clocks(8);
    chk("masked irq", {31'h0, irq}, 32'h0);
    rdc("dcc", ST, 32'hC0000000, 32'h80000000);
    wr(debug_uart_pkg::OFF_TAP, 32'h1);
    clocks(2);
    chk("tap", {31'h0, tap}, 32'h1);
    $display("test debug done");
  endtask : t_debug

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    nrst_in = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    dcc_rx = 1'b0;
    dcc_tx = 1'b0;
    ch_read = 1'b0;
    repeat (12) @(posedge clk_in);
    nrst_in <= 1'b1;
    t_reset();
    t_baud();
    t_parity();
    t_frame_over();
    t_start_detect();
    t_disable_reset();
    t_debug();
    test_done();
  end
endmodule : debug_uart_receiver_baud_tb
`default_nettype wire
